//--- divloop_exec.sv
// Execution unit for the unsigned divide and the count-down loop branch
`timescale 1ns/1ps
module divloop_exec
    import divloop_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Instruction from decode
    input wire logic instr_valid_i,
    input wire divloop_pkg::instr_t instr_i,
    // Working register window base (0xC0 region per pointer setting)
    input wire logic [7:0] work_base_i,
    // Register file read ports, combinational
    output logic [7:0] rd_addr_a_o,
    output logic [7:0] rd_addr_b_o,
    input wire logic [7:0] rd_data_a_i,
    input wire logic [7:0] rd_data_b_i,
    // Register file write and flags
    output divloop_pkg::rf_write_t rf_wr_o,
    output logic flags_we_o,
    output divloop_pkg::flags_t flags_o,
    // Completion and program counter
    output logic busy_o,
    output logic done_o,
    output logic [15:0] next_pc_o
);
    import divloop_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_READ = 6'b00_0010,
        ST_PTR = 6'b00_0100,
        ST_SRC = 6'b00_1000,
        ST_DIV = 6'b01_0000,
        ST_WAIT = 6'b10_0000
    } state_t;

    state_t state;
    logic is_div;
    logic [7:0] pair_hi;
    logic [7:0] divisor_addr;
    logic [7:0] imm;
    src_mode_t mode;
    logic [15:0] after_pc;
    logic [7:0] cnt;
    logic [15:0] rem;
    logic [7:0] quo;
    logic [7:0] dvs;
    logic [4:0] step;
    logic ovf;

    function automatic logic [7:0] work_reg(input logic [7:0] base, input logic [3:0] n);
        work_reg = {base[7:4], n};
    endfunction

    function automatic logic [7:0] even_reg(input logic [7:0] r);
        even_reg = {r[7:1], 1'b0};
    endfunction

    function automatic logic [7:0] odd_reg(input logic [7:0] r);
        odd_reg = {r[7:1], 1'b1};
    endfunction

    // Decode
    wire dec_div = (instr_i.opcode == OP_DIV_REG) || (instr_i.opcode == OP_DIV_IND)
        || (instr_i.opcode == OP_DIV_IMM);
    wire dec_loop = instr_i.opcode[3:0] == OP_LOOP_LO;
    wire start = clk_en_i && instr_valid_i && state == ST_IDLE && (dec_div || dec_loop);
    // Source seen in ST_SRC: the immediate byte, else the register addressed last
    wire [7:0] src_val = (mode == immediate_operand_mode) ? imm : rd_data_a_i;
    wire [7:0] loop_dec = rd_data_a_i - 8'h01;
    // One restoring step: the next dividend bit joins the partial remainder
    wire [8:0] trial = {rem[15:8], rem[7]};
    wire fits = trial >= {1'b0, dvs};

    // Addresses are registered, so an indirect source costs one extra cycle in ST_PTR
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_addr_a_o <= 8'h00;
            rd_addr_b_o <= 8'h00;
        end else if (clk_en_i) begin
            if (start) begin
                rd_addr_a_o <= dec_div ? even_reg(instr_i.byte2)
                    : work_reg(work_base_i, instr_i.opcode[7:4]);
                rd_addr_b_o <= odd_reg(instr_i.byte2);
            end else if (state == ST_READ) begin
                rd_addr_a_o <= divisor_addr;
            end else if (state == ST_PTR) begin
                rd_addr_a_o <= rd_data_a_i;
            end
        end
    end

    // Capture instruction and operands
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            is_div <= 1'b0;
            pair_hi <= 8'h00;
            divisor_addr <= 8'h00;
            imm <= 8'h00;
            mode <= register_pair_mode;
            after_pc <= PC_RESET;
        end else if (start) begin
            is_div <= dec_div;
            if (dec_div) begin
                // Byte1 = source, byte2 = destination pair (even)
                pair_hi <= {instr_i.byte2[7:1], 1'b0};
                divisor_addr <= instr_i.byte1;
                imm <= instr_i.byte1;
                mode <= src_mode_t'(instr_i.opcode[1:0] - 2'h0);
                after_pc <= instr_i.pc + 16'(DIV_LEN);
            end else begin
                pair_hi <= work_reg(work_base_i, instr_i.opcode[7:4]);
                imm <= instr_i.byte1;
                after_pc <= instr_i.pc + 16'(LOOP_LEN);
            end
        end
    end

    // Sequencer and divider
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            rem <= 16'h0000;
            quo <= 8'h00;
            dvs <= 8'h00;
            step <= 5'h00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rf_wr_o <= '0;
            flags_we_o <= 1'b0;
            flags_o <= '0;
            next_pc_o <= PC_RESET;
        end else if (clk_en_i) begin
            done_o <= 1'b0;
            flags_we_o <= 1'b0;
            rf_wr_o <= '0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_READ;
                        busy_o <= 1'b1;
                        cnt <= 8'h01;
                    end
                end
                ST_READ: begin
                    cnt <= cnt + 8'h01;
                    if (is_div) begin
                        // Unsigned dividend, high byte from the even register
                        rem <= {rd_data_a_i, rd_data_b_i};
                        state <= (mode == indirect_register_mode) ? ST_PTR : ST_SRC;
                    end else begin
                        rf_wr_o.we_hi <= 1'b1;
                        rf_wr_o.addr_hi <= pair_hi;
                        rf_wr_o.data_hi <= loop_dec;
                        // Signed displacement from the following byte
                        next_pc_o <= (loop_dec != 8'h00)
                            ? after_pc + {{8{imm[7]}}, imm} : after_pc;
                        state <= ST_WAIT;
                    end
                end
                ST_PTR: begin
                    cnt <= cnt + 8'h01;
                    state <= ST_SRC;
                end
                ST_SRC: begin
                    cnt <= cnt + 8'h01;
                    dvs <= src_val;
                    quo <= 8'h00;
                    step <= 5'h08;
                    state <= (src_val == 8'h00) ? ST_WAIT : ST_DIV;
                end
                ST_DIV: begin
                    cnt <= cnt + 8'h01;
                    // Only the low byte is shifted in: a high byte not below the divisor
                    // is an overflow anyway, so eight steps always suffice
                    if (step != 5'h00) begin
                        step <= step - 5'h01;
                        rem[7:0] <= {rem[6:0], 1'b0};
                        rem[15:8] <= fits ? 8'(trial - {1'b0, dvs}) : trial[7:0];
                        quo <= {quo[6:0], fits};
                    end else begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    cnt <= cnt + 8'h01;
                    if (is_div && dvs == 8'h00 && cnt == 8'(DIV_ZERO_CYCLES - 1)) begin
                        flags_we_o <= 1'b1;
                        flags_o <= '{c: 1'b0, z: 1'b1, s: 1'b0, v: 1'b1};
                        next_pc_o <= after_pc;
                        done_o <= 1'b1;
                        busy_o <= 1'b0;
                        state <= ST_IDLE;
                    end else if (is_div && dvs != 8'h00 && cnt == 8'(DIV_CYCLES - 1)) begin
                        rf_wr_o <= '{we_hi: 1'b1, addr_hi: pair_hi, data_hi: rem[15:8],
                            we_lo: 1'b1, addr_lo: odd_reg(pair_hi),
                            data_lo: quo};
                        flags_we_o <= 1'b1;
                        // A true quotient of 2^8 or more is never zero
                        flags_o <= '{c: 1'b0, z: !ovf && (quo == 8'h00), s: quo[7],
                            v: ovf};
                        next_pc_o <= after_pc;
                        done_o <= 1'b1;
                        busy_o <= 1'b0;
                        state <= ST_IDLE;
                    end else if (!is_div && cnt == 8'(LOOP_CYCLES - 1)) begin
                        done_o <= 1'b1;
                        busy_o <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Overflow: quotient needs more than 8 bits when the high byte is not below the divisor
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ovf <= 1'b0;
        end else if (clk_en_i && state == ST_SRC) begin
            ovf <= rem[15:8] >= src_val;
        end
    end

    // Loop op writes no flags
    loop_flags_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (state == ST_READ && !is_div) |=> !flags_we_o) else $error("loop wrote flags");
    div_zero_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (done_o && is_div && flags_o.v && dvs == 8'h00) |-> flags_o.z)
        else $error("zero divisor without zero flag");
    // The counter has already stepped past the last cycle when done shows
    div_time_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (done_o && is_div && dvs != 8'h00) |-> cnt == 8'h1A) else $error("divide time");
    zero_time_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (done_o && is_div && dvs == 8'h00) |-> cnt == 8'h0A) else $error("zero divide time");
    loop_time_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (done_o && !is_div) |-> cnt == 8'h08) else $error("loop time");
    rem_range_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (done_o && is_div && dvs != 8'h00 && !flags_o.v) |-> rf_wr_o.data_hi < dvs)
        else $error("remainder not below divisor");
    loop_fall_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (clk_en_i && state == ST_READ && !is_div && rd_data_a_i == 8'h01)
        |=> next_pc_o == after_pc) else $error("loop did not fall through");
    cov_div: cover property (@(posedge mclk_i) done_o && is_div);
    cov_loop: cover property (@(posedge mclk_i) done_o && !is_div);
    cov_zero: cover property (@(posedge mclk_i) done_o && is_div && dvs == 8'h00);
endmodule

//--- divloop_pkg.sv
// Package for the divide and count-down loop execution unit
package divloop_pkg;
    localparam logic [7:0] OP_DIV_REG = 8'h94;
    localparam logic [7:0] OP_DIV_IND = 8'h95;
    localparam logic [7:0] OP_DIV_IMM = 8'h96;
    localparam logic [3:0] OP_LOOP_LO = 4'hA;
    localparam int DIV_ZERO_CYCLES = 10;
    localparam int DIV_CYCLES = 26;
    localparam int LOOP_CYCLES = 8;
    localparam int DIV_LEN = 3;
    localparam int LOOP_LEN = 2;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // Source addressing of the divide
    typedef enum logic [1:0] {
        register_pair_mode = 2'h0,
        indirect_register_mode = 2'h1,
        immediate_operand_mode = 2'h2
    } src_mode_t;

    // Decoded instruction from fetch
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [15:0] pc;
    } instr_t;

    // Register file write request
    typedef struct packed {
        logic we_hi;
        logic [7:0] addr_hi;
        logic [7:0] data_hi;
        logic we_lo;
        logic [7:0] addr_lo;
        logic [7:0] data_lo;
    } rf_write_t;

    // Flags touched by the divide
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
    } flags_t;
endpackage

//--- tb.sv
// Self-checking testbench for the divide and count-down loop execution unit
`timescale 1ns/1ps
module tb;
    import divloop_pkg::*;
    typedef struct packed {
        logic [7:0] op;
        logic [15:0] dvd;
        logic [7:0] dvs;
        logic [7:0] quo;
        logic [7:0] rmd;
        logic v;
        logic z;
    } div_row_t;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    instr_t instr_i = '0;
    logic [7:0] rd_addr_a_o;
    logic [7:0] rd_addr_b_o;
    rf_write_t rf_wr_o;
    logic flags_we_o;
    logic busy_o;
    logic done_o;
    flags_t flags_o;
    flags_t fl;
    logic [15:0] next_pc_o;
    logic [7:0] rf [256];
    int num_errors = 0;
    int n_checks = 0;
    int nfw = 0;
    int lat = 0;
    // Dividend and divisor cover each mode, zero, overflow and the largest quotient
    // Columns: opcode, dividend, divisor, quotient, remainder, overflow, zero
    div_row_t rows [8] = '{
        '{OP_DIV_REG, 16'h1003, 8'h40, 8'h40, 8'h03, 1'b0, 1'b0},
        '{OP_DIV_IND, 16'h1003, 8'h80, 8'h20, 8'h03, 1'b0, 1'b0},
        '{OP_DIV_IMM, 16'h1003, 8'h20, 8'h80, 8'h03, 1'b0, 1'b0},
        '{OP_DIV_REG, 16'hFEFF, 8'hFF, 8'hFF, 8'hFE, 1'b0, 1'b0},
        '{OP_DIV_IMM, 16'h0005, 8'h10, 8'h00, 8'h05, 1'b0, 1'b1},
        '{OP_DIV_IND, 16'hFFFF, 8'h01, 8'h00, 8'h00, 1'b1, 1'b0},
        '{OP_DIV_REG, 16'h1234, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1},
        '{OP_DIV_IMM, 16'h0100, 8'h01, 8'h00, 8'h00, 1'b1, 1'b0}};

    divloop_exec dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .work_base_i(8'hC0),
        .rd_addr_a_o(rd_addr_a_o), .rd_addr_b_o(rd_addr_b_o),
        .rd_data_a_i(rf[rd_addr_a_o]), .rd_data_b_i(rf[rd_addr_b_o]),
        .rf_wr_o(rf_wr_o), .flags_we_o(flags_we_o), .flags_o(flags_o),
        .busy_o(busy_o), .done_o(done_o), .next_pc_o(next_pc_o));

    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    // Register file and flag register stand in for the rest of the core
    always @(posedge mclk_i) begin
        if (rf_wr_o.we_hi === 1'b1) rf[rf_wr_o.addr_hi] <= rf_wr_o.data_hi;
        if (rf_wr_o.we_lo === 1'b1) rf[rf_wr_o.addr_lo] <= rf_wr_o.data_lo;
        if (flags_we_o !== 1'b0) begin
            fl <= flags_o;
            nfw <= nfw + 1;
        end
    end

    task automatic check(input logic c, input string msg);
        n_checks++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One request, then a bounded wait for completion plus one spare cycle
    task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [15:0] pc);
        @(posedge mclk_i);
        #1;
        instr_i = '{op, b1, 8'hC0, pc};
        instr_valid_i = 1'b1;
        @(posedge mclk_i);
        #1;
        instr_valid_i = 1'b0;
        lat = 0;
        while (done_o !== 1'b1 && lat < 100) begin
            @(posedge mclk_i);
            #1;
            lat++;
        end
        @(posedge mclk_i);
        #1;
    endtask

    task automatic div_test(input div_row_t d);
        int fw;
        rf[8'hC0] = d.dvd[15:8];
        rf[8'hC1] = d.dvd[7:0];
        rf[8'hC2] = (d.op == OP_DIV_IND) ? 8'h40 : d.dvs;
        rf[8'h40] = d.dvs;
        fw = nfw;
        run(d.op, (d.op == OP_DIV_IMM) ? d.dvs : 8'hC2, 16'h1000);
        check(lat == ((d.dvs == 8'h00) ? DIV_ZERO_CYCLES : DIV_CYCLES) - 1, "div time");
        check(nfw == fw + 1, "div flags not written");
        check(fl.v === d.v, "div overflow");
        check(fl.z === d.z, "div zero");
        check(next_pc_o === 16'h1000 + 16'(DIV_LEN), "div next pc");
        if (!d.v) begin
            check(rf[8'hC0] === d.rmd, "div remainder");
            check(rf[8'hC1] === d.quo, "div quotient");
            check(fl.s === d.quo[7], "div sign");
        end
        $display("div op %h dvd %h dvs %h done", d.op, d.dvd, d.dvs);
    endtask

    task automatic loop_test(input logic [3:0] r, input logic [7:0] cnt, input logic [7:0] disp);
        logic [7:0] nc;
        logic [15:0] exp_pc;
        int fw;
        nc = cnt - 8'h01;
        exp_pc = 16'h2000 + 16'(LOOP_LEN);
        if (nc != 8'h00) exp_pc = exp_pc + {{8{disp[7]}}, disp};
        fw = nfw;
        rf[{4'hC, r}] = cnt;
        run({r, OP_LOOP_LO}, disp, 16'h2000);
        check(rf[{4'hC, r}] === nc, "loop count");
        check(next_pc_o === exp_pc, "loop target");
        check(nfw == fw, "loop flags");
        check(lat == LOOP_CYCLES - 1, "loop time");
        $display("loop r %0d count %h disp %h done", r, cnt, disp);
    endtask

    initial begin
        #200000;
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge mclk_i);
        #1;
        check(busy_o === 1'b0 && done_o === 1'b0 && next_pc_o === 16'h0000, "reset outputs");
        reset_n_i = 1'b1;
        foreach (rows[i]) div_test(rows[i]);
        // Counter 1 falls through, counter 0 wraps round and branches
        for (int i = 0; i < 16; i++) loop_test(i[3:0], i[7:0], i[0] ? 8'h80 : 8'h7F);
        // A loop request while a divide is busy must be ignored
        rf[8'hC5] = 8'h33;
        fork
            div_test(rows[0]);
            begin
                repeat (5) @(posedge mclk_i);
                #1;
                instr_i = '{{4'h5, OP_LOOP_LO}, 8'h10, 8'h00, 16'h3000};
                instr_valid_i = 1'b1;
                @(posedge mclk_i);
                #1;
                instr_valid_i = 1'b0;
            end
        join
        check(rf[8'hC5] === 8'h33, "busy request taken");
        $display("busy refusal done");
        // Reset in mid-divide, then a clean divide
        run(OP_DIV_REG, 8'hC2, 16'h1000);
        instr_valid_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        instr_valid_i = 1'b0;
        reset_n_i = 1'b0;
        #1;
        check(busy_o === 1'b0 && done_o === 1'b0 && next_pc_o === PC_RESET, "mid reset");
        @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        div_test(rows[2]);
        $display("mid reset done");
        stop_test();
    end
endmodule
